/* File: adcp_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides
// Assumes one clock and asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module adcp_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_arst_n,
  // Fill side
  adcp_stream_if.snk s_in,
  // Drain side
  output logic         o_valid,
  output logic [W-1:0] o_data,
  input  wire logic    i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire          empty = (wr_q == rd_q);
  wire          push  = s_in.valid && !full;
  wire          pop   = i_ready && !empty;
  assign s_in.ready = !full;
  assign o_valid    = !empty;
  assign o_data     = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= s_in.data;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: adcp_host_model.sv */
// Host processor model on the byte-wide port
// Assumes the design synchronises strobes with four flops
`timescale 1ns/1ns
`default_nettype none
module adcp_host_model (
  // Clock
  input  wire logic       i_clk_sys,
  // Host pins
  output logic            o_cs_n,
  output logic            o_wr_n,
  output logic            o_rd_n,
  output logic            o_upper_byte_select,
  output logic [7:0]      o_data,
  // Read back
  input  wire logic [7:0] i_rd_data,
  input  wire logic [7:0] i_rd_oe
);
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_upper_byte_select = 1'b0;
    o_data = 8'h00;
  end
  // Write strobe pulse, data held past the synchroniser
  task automatic write_byte(input logic [7:0] b);
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    o_wr_n <= 1'b0;
    o_data <= b;
    repeat (2) @(posedge i_clk_sys);
    o_wr_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    o_cs_n <= 1'b1;
    o_data <= ~b;
    // Let the synchronised write take effect
    repeat (3) @(posedge i_clk_sys);
  endtask
  // Read one byte after the strobe settles
  task automatic read_byte(input logic ube, output logic [7:0] d, output logic [7:0] oe);
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    o_upper_byte_select <= ube;
    repeat (6) @(posedge i_clk_sys);
    d = i_rd_data;
    oe = i_rd_oe;
    o_rd_n <= 1'b1;
    o_cs_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

/* File: adcp_params.svh */
// Constants for the parallel converter control logic
// Assumes inclusion by bare name from the design files
`ifndef ADCP_PARAMS_SVH
`define ADCP_PARAMS_SVH
`define ADCP_CLK_HZ        25000000
`define ADCP_BIT_PM_HI     7
`define ADCP_BIT_PM_LO     6
`define ADCP_BIT_ACQ       5
`define ADCP_BIT_SGL       4
`define ADCP_BIT_UNI       3
`define ADCP_CTRL_RESET    8'hc8
`define ADCP_RESULT_W      10
`define ADCP_CONV_CYCLES   13
`define ADCP_FIFO_DEPTH    32
`endif

/* File: adcp_pkg.sv */
// Types for the parallel converter control logic
// Assumes adcp_params.svh is on the include path
package adcp_pkg;
  typedef enum logic [1:0] {
    ADCP_PM_FULL_DOWN = 2'b00,
    ADCP_PM_STANDBY   = 2'b01,
    ADCP_PM_NORM_INT  = 2'b10,
    ADCP_PM_NORM_EXT  = 2'b11
  } adcp_pmode_e;
  typedef enum logic [1:0] {
    ADCP_ST_RUN,
    ADCP_ST_CONV,
    ADCP_ST_STANDBY,
    ADCP_ST_SHUTDOWN
  } adcp_state_e;
endpackage

/* File: adcp_stream_if.sv */
// Result stream between converter core and output FIFO
// Assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface adcp_stream_if #(parameter int W = 10);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: adcp_top.sv */
// Control logic of a 10-bit converter with byte-wide host port
// Assumes host pins are asynchronous; core result arrives on i_clk_sys
//
// Summary of operation
// RL1 - Control byte: power, acq, config, polarity, address
// RL2 - Single-ended: addressed input against shared negative
// RL3 - Differential: pair by bits 2:1, bit0 polarity
// RL4 - Reset selects external clock, done high
// RL5 - Host waits 10us after reset
// RL6 - Host waits 500us for internal reference
// RL7 - Upper byte select picks low or sign-filled high
// RL8 - Power bits 7:6 pick standby or shutdown
// RL9 - Port works in power-down, no conversions
// RL10 - Standby exits on write strobe rising edge
// RL11 - Shutdown waits for running conversion to finish
// RL12 - Write strobe rising edge exits shutdown
// RL13 - Host waits for accuracy after shutdown
// RL14 - Host enters standby by dummy conversion
// RL15 - Unipolar result plain binary, LSB ref/1024
// RL16 - Power bits: 00 down,01 standby,1x normal
// RL17 - Power-down keeps last clock mode
// RL18 - Control byte captured from data lines
// RL19 - Unipolar straight binary, bipolar twos complement
// RL20 - Host reads after done goes low
`timescale 1ns/1ns
`default_nettype none
`include "adcp_params.svh"
module adcp_top #(
  parameter int N_INPUTS = 8,
  parameter int CONV_CYCLES = `ADCP_CONV_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  // Host port
  input  wire logic       i_cs_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_upper_byte_select,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic      [7:0] o_data_oe,
  // Conversion core
  input  wire logic [9:0] i_core_result,
  output logic            o_ext_clock_mode,
  output logic            o_ext_sampling,
  output logic            o_powered,
  output logic            o_standby,
  output logic [7:0]      o_pos_sel,
  output logic [7:0]      o_neg_sel,
  output logic            o_neg_shared,
  output logic            o_busy,
  output logic            o_conv_done_n
);
  // Pin synchronisers
  logic [1:0] wr_s1_q, wr_s2_q, rd_s1_q, rd_s2_q, cs_s1_q, cs_s2_q;
  logic [7:0] d_s1_q, d_s2_q;
  logic       hb_s1_q, hb_s2_q;
  logic       wr_n_d1_q;
  logic       cs_n_d1_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {wr_s1_q, wr_s2_q, rd_s1_q, rd_s2_q, cs_s1_q, cs_s2_q} <= 12'hfff;
      cs_n_d1_q <= 1'b1;
      d_s1_q    <= 8'h00;
      d_s2_q    <= 8'h00;
      hb_s1_q   <= 1'b0;
      hb_s2_q   <= 1'b0;
      wr_n_d1_q <= 1'b1;
    end else begin
      wr_s1_q   <= {wr_s1_q[0], i_wr_n};
      wr_s2_q   <= {wr_s2_q[0], wr_s1_q[1]};
      rd_s1_q   <= {rd_s1_q[0], i_rd_n};
      rd_s2_q   <= {rd_s2_q[0], rd_s1_q[1]};
      cs_s1_q   <= {cs_s1_q[0], i_cs_n};
      cs_s2_q   <= {cs_s2_q[0], cs_s1_q[1]};
      d_s1_q    <= i_data;
      d_s2_q    <= d_s1_q;
      hb_s1_q   <= i_upper_byte_select;
      hb_s2_q   <= hb_s1_q;
      wr_n_d1_q <= wr_s2_q[1];
      cs_n_d1_q <= cs_s2_q[1];
    end
  end
  wire wr_n_s = wr_s2_q[1];
  wire rd_n_s = rd_s2_q[1];
  wire cs_n_s = cs_s2_q[1];
  // Select qualified one cycle back: host may release select with the strobe
  wire wr_rise = wr_n_s && !wr_n_d1_q && !cs_n_d1_q;

  // Control word
  logic [7:0] ctrl_q;
  logic       clk_ext_q;
  wire [1:0]  pm_w  = d_s2_q[`ADCP_BIT_PM_HI:`ADCP_BIT_PM_LO];
  wire        norm_w = pm_w[1];
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q    <= `ADCP_CTRL_RESET;
      clk_ext_q <= 1'b1; // RL4
    end else if (wr_rise) begin
      ctrl_q <= d_s2_q; // RL18 RL1
      if (norm_w) begin
        clk_ext_q <= pm_w[0]; // RL16 RL17
      end
    end
  end
  wire       sgl   = ctrl_q[`ADCP_BIT_SGL];
  wire       uni   = ctrl_q[`ADCP_BIT_UNI];
  wire [2:0] addr  = ctrl_q[2:0];
  wire [2:0] pos_i = sgl ? addr : {addr[2:1], addr[0]};
  wire [2:0] neg_i = {addr[2:1], ~addr[0]};
  wire [7:0] in_mask = 8'((16'h1 << N_INPUTS) - 16'h1);
  assign o_pos_sel    = (8'h01 << pos_i) & in_mask; // RL2 RL3
  assign o_neg_sel    = sgl ? 8'h00 : ((8'h01 << neg_i) & in_mask); // RL3
  assign o_neg_shared = sgl; // RL2
  assign o_ext_clock_mode = clk_ext_q;
  assign o_ext_sampling   = ctrl_q[`ADCP_BIT_ACQ];

  // Power and conversion sequencing
  adcp_pkg::adcp_state_e st_q, st_d;
  logic [4:0] cnt_q;
  logic       done_n_q;
  logic       pend_q;
  wire        conv_end = (st_q == adcp_pkg::ADCP_ST_CONV) && (cnt_q == 5'(CONV_CYCLES - 1));
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      adcp_pkg::ADCP_ST_RUN: begin
        if (wr_rise && norm_w) st_d = adcp_pkg::ADCP_ST_CONV;
        else if (wr_rise && pm_w == 2'b01) st_d = adcp_pkg::ADCP_ST_STANDBY; // RL8
        else if (wr_rise) st_d = adcp_pkg::ADCP_ST_SHUTDOWN; // RL8
      end
      adcp_pkg::ADCP_ST_CONV: begin
        if (conv_end && pend_q) st_d = adcp_pkg::ADCP_ST_SHUTDOWN; // RL11
        else if (conv_end) st_d = adcp_pkg::ADCP_ST_RUN;
      end
      adcp_pkg::ADCP_ST_STANDBY: begin
        if (wr_rise) st_d = norm_w ? adcp_pkg::ADCP_ST_CONV : adcp_pkg::ADCP_ST_RUN; // RL10 RL9
      end
      adcp_pkg::ADCP_ST_SHUTDOWN: begin
        if (wr_rise) st_d = norm_w ? adcp_pkg::ADCP_ST_CONV : adcp_pkg::ADCP_ST_RUN; // RL12 RL9
      end
    endcase
  end
  adcp_stream_if #(.W(`ADCP_RESULT_W)) res_if ();
  assign res_if.valid = conv_end;
  assign res_if.data  = i_core_result; // RL15 RL19
  wire stall = (st_q == adcp_pkg::ADCP_ST_CONV) && !res_if.ready;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q     <= adcp_pkg::ADCP_ST_RUN;
      cnt_q    <= 5'h00;
      done_n_q <= 1'b1; // RL4
      pend_q   <= 1'b0;
    end else if (!stall) begin
      st_q  <= st_d;
      cnt_q <= (st_q == adcp_pkg::ADCP_ST_CONV && !conv_end) ? cnt_q + 5'h01 : 5'h00;
      if (wr_rise) done_n_q <= 1'b1;
      else if (conv_end) done_n_q <= 1'b0;
      if (st_q == adcp_pkg::ADCP_ST_CONV && wr_rise && pm_w == 2'b00) pend_q <= 1'b1; // RL11
      else if (conv_end) pend_q <= 1'b0;
    end
  end
  assign o_busy        = (st_q == adcp_pkg::ADCP_ST_CONV);
  assign o_powered     = (st_q == adcp_pkg::ADCP_ST_RUN) || (st_q == adcp_pkg::ADCP_ST_CONV);
  assign o_standby     = (st_q == adcp_pkg::ADCP_ST_STANDBY);
  assign o_conv_done_n = done_n_q;

  // Result buffer and readout
  logic       f_valid;
  logic [9:0] f_data;
  logic [9:0] res_q;
  logic       rd_n_d1_q;
  logic       res_q_loaded;
  wire        rd_end = rd_n_s && !rd_n_d1_q && !cs_n_d1_q && hb_s2_q;
  adcp_fifo #(.W(`ADCP_RESULT_W), .DEPTH(`ADCP_FIFO_DEPTH)) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .s_in      (res_if),
    .o_valid   (f_valid),
    .o_data    (f_data),
    .i_ready   (rd_end || !res_q_loaded)
  );
  logic [7:0] out_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      res_q        <= 10'h000;
      res_q_loaded <= 1'b0;
      rd_n_d1_q    <= 1'b1;
      out_q        <= 8'h00;
    end else begin
      rd_n_d1_q <= rd_n_s;
      if (f_valid && (rd_end || !res_q_loaded)) begin
        res_q        <= f_data;
        res_q_loaded <= 1'b1;
      end else if (rd_end) begin
        // Result consumed; next arrival loads straight away
        res_q_loaded <= 1'b0;
      end
      out_q <= hb_s2_q ? {{6{res_q[9] & ~uni}}, res_q[9:8]} : res_q[7:0]; // RL7
    end
  end
  wire rd_act = !cs_n_s && !rd_n_s;
  assign o_data    = out_q;
  assign o_data_oe = {8{rd_act}}; // RL9

  AST_RESET_DONE_HIGH: assert property (@(posedge i_clk_sys) $rose(i_arst_n) |-> o_conv_done_n && o_ext_clock_mode) // RL4
    else $error("done or clock mode wrong after reset");
  AST_UNIPOLAR_FILL: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    $past(hb_s2_q) && $past(uni) |-> o_data[7:2] == 6'h00) // RL7
    else $error("unipolar fill not zero");
  AST_BIPOLAR_FILL: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    $past(hb_s2_q) && !$past(uni) |-> o_data[7:2] == {6{$past(res_q[9])}}) // RL7
    else $error("bipolar fill not sign");
  AST_SGL_NEG: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    sgl |-> o_neg_sel == 8'h00 && o_neg_shared) // RL2
    else $error("single-ended negative wrong");
  AST_DIF_PAIR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !sgl && N_INPUTS == 8 |-> (o_pos_sel | o_neg_sel) == (8'h03 << {addr[2:1], 1'b0})) // RL3
    else $error("differential pair wrong");
  AST_CLK_KEPT: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    wr_rise && !norm_w |=> $stable(o_ext_clock_mode)) // RL17
    else $error("clock mode changed in power-down");
  AST_SHUTDOWN_WAITS: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_busy && !conv_end |=> st_q != adcp_pkg::ADCP_ST_SHUTDOWN) // RL11
    else $error("shutdown before conversion end");
  AST_WAKE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !o_powered && wr_rise && norm_w |=> o_busy) // RL10 RL12
    else $error("no wake on write");
  AST_NO_CONV_DOWN: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !o_powered |-> !o_busy ##1 (o_busy -> $past(wr_rise))) // RL9
    else $error("conversion while powered down");
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the converter control logic
// Assumes the host model file is compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       i_clk_sys = 1'b0;
  logic       i_arst_n = 1'b0;
  logic       cs_n, wr_n, rd_n, ube, ext_clk, ext_smp, powered, standby, busy, done_n, neg_shared;
  logic [7:0] din, dout, oe, pos_sel, neg_sel, rd, rdoe;
  logic [9:0] core = 10'h2a5;
  int         num_errors = 0;
  int         checked = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  adcp_top i_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cs_n(cs_n), .i_wr_n(wr_n),
    .i_rd_n(rd_n), .i_upper_byte_select(ube), .i_data(din), .o_data(dout), .o_data_oe(oe),
    .i_core_result(core), .o_ext_clock_mode(ext_clk), .o_ext_sampling(ext_smp),
    .o_powered(powered), .o_standby(standby), .o_pos_sel(pos_sel), .o_neg_sel(neg_sel),
    .o_neg_shared(neg_shared), .o_busy(busy), .o_conv_done_n(done_n));
  adcp_host_model i_host (.i_clk_sys(i_clk_sys), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
    .o_upper_byte_select(ube), .o_data(din), .i_rd_data(dout), .i_rd_oe(oe));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait for conversion done
  task automatic wait_done();
    int n;
    n = 0;
    while (done_n !== 1'b0 && n < 200) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (done_n !== 1'b0) begin
      num_errors++;
      print_verdict();
    end
  endtask
  // Read both bytes and compare
  task automatic read_pair(input logic [7:0] lo, input logic [7:0] hi);
    i_host.read_byte(1'b0, rd, rdoe);
    check(rd, lo);
    check(rdoe, 8'hff);
    i_host.read_byte(1'b1, rd, rdoe);
    check(rd, hi);
  endtask
  initial begin
    repeat (20) @(posedge i_clk_sys);
    check(done_n, 1'b1);
    check(ext_clk, 1'b1);
    check(oe, 8'h00);
    i_arst_n <= 1'b1;
    // Host waits out internal reset
    repeat (10) @(posedge i_clk_sys);
    // Single-ended, unipolar, input 2
    i_host.write_byte(8'hda);
    check(pos_sel, 8'h04);
    check(neg_shared, 1'b1);
    check(ext_smp, 1'b0);
    wait_done();
    read_pair(8'ha5, 8'h02);
    // Differential pair 2/3, odd positive, bipolar, new result
    core <= 10'h35a;
    i_host.write_byte(8'he3);
    check(pos_sel, 8'h08);
    check(neg_sel, 8'h04);
    check(neg_shared, 1'b0);
    check(ext_smp, 1'b1);
    wait_done();
    read_pair(8'h5a, 8'hff);
    // Internal clock, then standby keeps clock mode
    i_host.write_byte(8'h98);
    check(ext_clk, 1'b0);
    wait_done();
    i_host.write_byte(8'h58);
    check(standby, 1'b1);
    check(ext_clk, 1'b0);
    i_host.write_byte(8'hd8);
    check(standby, 1'b0);
    check(ext_clk, 1'b1);
    wait_done();
    // Shutdown, port stays alive
    i_host.write_byte(8'h18);
    repeat (20) @(posedge i_clk_sys);
    check(powered, 1'b0);
    i_host.read_byte(1'b1, rd, rdoe);
    check(rdoe, 8'hff);
    check(busy, 1'b0);
    i_host.write_byte(8'hd8);
    check(powered, 1'b1);
    wait_done();
    // Shutdown requested mid-conversion waits for the end
    repeat (8) @(posedge i_clk_sys);
    i_host.write_byte(8'hd8);
    i_host.write_byte(8'h18);
    check(powered, 1'b1);
    check(busy, 1'b1);
    wait_done();
    repeat (4) @(posedge i_clk_sys);
    check(powered, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
